// ==== hw/hvs_sync_proc.sv ====
// Horizontal and vertical sync processor with counters and separator.
// Assumes sync pins asynchronous; control bits come from a CPU register.
`timescale 1ns/100ps
module hvs_sync_proc
	import hvs_pkg::*;
#(
	parameter int VTICK  = VTICK_CYC,
	parameter int WIN0   = WIN0_CYC,
	parameter int WIN1   = WIN1_CYC,
	parameter int INSW   = INS_CYC,
	parameter int WIDEN  = WIDEN_CYC
)(
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              horiz_sync_in,
	input  wire logic              vert_sync_in,
	input  wire hvs_pkg::hvs_ctrl_t ctrl,
	input  wire logic              port0_pin6_gpio,
	input  wire logic              port0_pin7_gpio,
	output hvs_pkg::hvs_stat_t     stat,
	output logic                   port0_pin6_out,
	output logic                   port0_pin7_out,
	output logic                   horiz_sync_out,
	output logic                   vert_sync_out
);
	import hvs_pkg::*;

	logic h_lvl, h_rise, v_lvl, v_rise;
	logic [VCNT_W-1:0] vcnt_r, vlat_r;
	logic [10:0]       vpre_r;
	logic              vov_r;
	logic [HCNT_W-1:0] hcnt_r, hlat_r;
	logic              hov_r;
	logic [27:0]       win_r;
	logic              win_end;
	logic              hpol_r, vpol_r;
	logic [15:0]       hhigh_r, vhigh_r, hper_cnt_r;
	logic [15:0]       line_r, lcnt_r;
	logic              vsep_r;
	logic [15:0]       comp_low_r;
	logic [15:0]       widen_r;
	logic              vwide;
	logic [15:0]       ins_r;
	logic              ins_pulse;
	logic              h_raw, v_src_d, v_edge, h_edge;
	logic              hsrc, vsrc_sig;

	// Separate filter instance on each pin
	hvs_filter #(.MIN_CYC(GLITCH_CYC)) u_hf
	(
		.clock (clock),
		.rst   (rst),
		.pin   (horiz_sync_in),
		.level (h_lvl),
		.rise  (h_rise)
	);

	hvs_filter #(.MIN_CYC(GLITCH_CYC)) u_vf
	(
		.clock (clock),
		.rst   (rst),
		.pin   (vert_sync_in),
		.level (v_lvl),
		.rise  (v_rise)
	);

	// Polarity: a level held high most of the time is a negative pulse.
	// Compare high time with half of a 65536-cycle sampling period.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			hhigh_r    <= 16'h0000;
			vhigh_r    <= 16'h0000;
			hper_cnt_r <= 16'h0000;
			hpol_r     <= 1'b1;
			vpol_r     <= 1'b1;
		end
		else
		begin
			hper_cnt_r <= hper_cnt_r + 16'h0001;
			if (hper_cnt_r == 16'hffff)
			begin
				hpol_r  <= hhigh_r[15] == 1'b0;
				vpol_r  <= vhigh_r[15] == 1'b0;
				hhigh_r <= 16'h0000;
				vhigh_r <= 16'h0000;
			end
			else
			begin
				hhigh_r <= hhigh_r + {15'h0000, h_lvl};
				vhigh_r <= vhigh_r + {15'h0000, v_lvl};
			end
		end
	end

	// Active-high normalised inputs
	assign h_raw = h_lvl ~^ hpol_r;
	assign hsrc  = h_raw;

	// Composite separator: a horizontal-input pulse wider than half a
	// line marks vertical sync; it starts the cycle after its count reaches half a line.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			comp_low_r <= 16'h0000;
			vsep_r     <= 1'b0;
		end
		else if (!h_raw)
		begin
			comp_low_r <= 16'h0000;
			vsep_r     <= 1'b0;
		end
		else
		begin
			if (comp_low_r != 16'hffff)
				comp_low_r <= comp_low_r + 16'h0001;
			if (comp_low_r == {1'b0, line_r[15:1]} && line_r != 16'h0000)
				vsep_r <= 1'b1;
		end
	end

	// Vertical source: separate pin or the separator output
	assign vsrc_sig = ctrl.sep_comp_sel ? (v_lvl ~^ vpol_r) : vsep_r;

	always_ff @(posedge clock)
	begin
		if (rst)
			v_src_d <= 1'b0;
		else
			v_src_d <= vsrc_sig;
	end
	assign v_edge = vsrc_sig && !v_src_d;
	// One count per pulse in either polarity; none in composite vertical
	assign h_edge = h_rise && (ctrl.sep_comp_sel || !vsrc_sig);

	// Widen the extracted vertical pulse to guard insertion
	always_ff @(posedge clock)
	begin
		if (rst)
			widen_r <= 16'h0000;
		else if (vsrc_sig)
			widen_r <= 16'(WIDEN);
		else if (widen_r != 16'h0000)
			widen_r <= widen_r - 16'h0001;
	end
	assign vwide = vsrc_sig || (!ctrl.sep_comp_sel && widen_r != 16'h0000);

	// Line interval measured between real pulses outside vertical sync
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			lcnt_r <= 16'h0000;
			line_r <= 16'h0000;
		end
		else if (h_rise && !vwide)
		begin
			line_r <= lcnt_r + 16'h0001;
			lcnt_r <= 16'h0000;
		end
		else if (lcnt_r != 16'hffff)
			lcnt_r <= lcnt_r + 16'h0001;
	end

	// Insertion timer: restarts from each last real or inserted pulse,
	// clocked at 5 ns so phase error is one cycle, under 125 ns.
	always_ff @(posedge clock)
	begin
		if (rst)
			ins_r <= 16'h0000;
		else if (!vwide || ctrl.pulse_insert_enable_n)
			ins_r <= lcnt_r + 16'h0001;
		else if (ins_r + 16'h0001 >= line_r)
			ins_r <= 16'h0000;
		else
			ins_r <= ins_r + 16'h0001;
	end
	assign ins_pulse = vwide && !ctrl.pulse_insert_enable_n
		&& !ctrl.sep_comp_sel && line_r != 16'h0000
		&& ins_r < 16'(INSW);

	// Vertical period counter with 8 us prescaler
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			vpre_r <= 11'h000;
			vcnt_r <= '0;
			vlat_r <= '0;
		end
		else if (v_edge)
		begin
			vlat_r <= vcnt_r;
			vcnt_r <= '0;
			vpre_r <= 11'h000;
		end
		else if (vpre_r == 11'(VTICK - 1))
		begin
			vpre_r <= 11'h000;
			vcnt_r <= vcnt_r + VCNT_W'(1);
		end
		else
			vpre_r <= vpre_r + 11'h001;
	end

	// Sticky vertical overflow; a set in the clear cycle wins
	always_ff @(posedge clock)
	begin
		if (rst)
			vov_r <= 1'b0;
		else if (vpre_r == 11'(VTICK - 1) && &vcnt_r && !v_edge)
			vov_r <= 1'b1;
		else if (ctrl.vert_overflow_clear)
			vov_r <= 1'b0;
	end

	// Window prescaler for fixed-interval horizontal counting
	always_ff @(posedge clock)
	begin
		if (rst || ctrl.interval_mode_enable_n)
			win_r <= 28'h0000000;
		else if (win_end)
			win_r <= 28'h0000000;
		else
			win_r <= win_r + 28'h0000001;
	end
	assign win_end = !ctrl.interval_mode_enable_n && (ctrl.interval_sel
		? win_r == 28'(WIN1 - 1) : win_r == 28'(WIN0 - 1));

	// Horizontal counter and latch; overflow clear never touches hcnt_r
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			hcnt_r <= '0;
			hlat_r <= '0;
		end
		else if (ctrl.interval_mode_enable_n ? v_edge : win_end)
		begin
			hlat_r <= hcnt_r;
			hcnt_r <= h_edge ? HCNT_W'(1) : '0;
		end
		else if (h_edge && !(&hcnt_r))
			hcnt_r <= hcnt_r + HCNT_W'(1);
	end

	// Sticky horizontal overflow
	always_ff @(posedge clock)
	begin
		if (rst)
			hov_r <= 1'b0;
		else if (h_edge && &hcnt_r)
			hov_r <= 1'b1;
		else if (ctrl.horiz_overflow_clear)
			hov_r <= 1'b0;
	end

	// Outputs: separate passes combinationally, composite adds the synchroniser and glitch-filter delay
	always_comb
	begin
		if (ctrl.sep_comp_sel)
		begin
			vert_sync_out  = vert_sync_in ~^ (vpol_r ~^ ctrl.vert_out_polarity);
			horiz_sync_out = horiz_sync_in ~^
				(hpol_r ~^ ctrl.horiz_out_polarity);
		end
		else
		begin
			vert_sync_out  = vwide ~^ ctrl.vert_out_polarity;
			horiz_sync_out = ((hsrc && !vsrc_sig) || ins_pulse)
				~^ ctrl.horiz_out_polarity;
		end
	end

	// Shared pins: enable low selects sync output
	assign port0_pin6_out = ctrl.vert_output_enable_n
		? port0_pin6_gpio : vert_sync_out;
	assign port0_pin7_out = ctrl.horiz_output_enable_n
		? port0_pin7_gpio : horiz_sync_out;

	// Status readback
	always_comb
	begin
		stat.vert_period_count    = vlat_r;
		stat.horiz_pulse_count    = hlat_r;
		stat.vert_count_overflow  = vov_r;
		stat.horiz_count_overflow = hov_r;
		stat.horiz_in_polarity    = hpol_r;
		stat.vert_in_polarity     = vpol_r;
		stat.horiz_sync_level     = h_lvl;
		stat.vert_sync_level      = v_lvl;
	end

	// Assertions
	property p_vlatch;
		@(posedge clock) disable iff (rst)
		v_edge |=> vlat_r == $past(vcnt_r);
	endproperty
	a_vlatch: assert property (p_vlatch) else $error("vlatch");

	property p_vov_sticky;
		@(posedge clock) disable iff (rst)
		vov_r && !ctrl.vert_overflow_clear |=> vov_r;
	endproperty
	a_vov_sticky: assert property (p_vov_sticky) else $error("vov");

	property p_hov_sticky;
		@(posedge clock) disable iff (rst)
		hov_r && !ctrl.horiz_overflow_clear |=> hov_r;
	endproperty
	a_hov_sticky: assert property (p_hov_sticky) else $error("hov");

	property p_hclr_keeps;
		@(posedge clock) disable iff (rst)
		ctrl.horiz_overflow_clear && !h_edge && !v_edge && !win_end
		|=> hcnt_r == $past(hcnt_r);
	endproperty
	a_hclr_keeps: assert property (p_hclr_keeps)
		else $error("hcnt reset by clear");

	property p_hlatch;
		@(posedge clock) disable iff (rst)
		ctrl.interval_mode_enable_n && v_edge |=> hlat_r == $past(hcnt_r);
	endproperty
	a_hlatch: assert property (p_hlatch) else $error("hlatch");

	property p_win;
		@(posedge clock) disable iff (rst)
		win_end |=> win_r == 28'h0000000;
	endproperty
	a_win: assert property (p_win) else $error("window");

	property p_pin6;
		@(posedge clock) disable iff (rst)
		!ctrl.vert_output_enable_n |-> port0_pin6_out == vert_sync_out;
	endproperty
	a_pin6: assert property (p_pin6) else $error("pin6 mux");

	property p_stat;
		@(posedge clock) disable iff (rst)
		stat.horiz_sync_level == h_lvl && stat.vert_sync_level == v_lvl;
	endproperty
	a_stat: assert property (p_stat) else $error("levels");

	c_vedge: cover property (@(posedge clock) disable iff (rst) v_edge);
	c_vov:   cover property (@(posedge clock) disable iff (rst) $rose(vov_r));
	c_ins:   cover property (@(posedge clock) disable iff (rst) ins_pulse);
	c_win:   cover property (@(posedge clock) disable iff (rst) win_end);
endmodule

// ==== include/hvs_pkg.sv ====
// Constants and carrier types for the sync processor.
// Assumes a 200 MHz system clock; all counts derive from it.
package hvs_pkg;
	localparam int CLK_MHZ          = 200;
	localparam int CLK_PERIOD_PS    = 5000;
	// Glitch filter: least width 125 ns, rounded up to cycles
	localparam int GLITCH_NS        = 125;
	localparam int GLITCH_CYC       = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	// Vertical period tick of 8 us
	localparam int VTICK_US         = 8;
	localparam int VTICK_CYC        = VTICK_US * CLK_MHZ;
	// Fixed horizontal counting windows, in us
	localparam int WIN0_US          = 16384;
	localparam int WIN1_US          = 32768;
	localparam int WIN0_CYC         = WIN0_US * CLK_MHZ;
	localparam int WIN1_CYC         = WIN1_US * CLK_MHZ;
	// Inserted pulse width 2 us and vertical widening about 9 us
	localparam int INS_US           = 2;
	localparam int INS_CYC          = INS_US * CLK_MHZ;
	localparam int WIDEN_US         = 9;
	localparam int WIDEN_CYC        = WIDEN_US * CLK_MHZ;
	// Counter widths
	localparam int VCNT_W           = 14;
	localparam int HCNT_W           = 12;
	// Reset values of the control bits
	localparam logic RST_INTERVAL_EN_N = 1'b1;
	localparam logic RST_INTERVAL_SEL  = 1'b1;
	localparam logic RST_SEP_COMP      = 1'b1;
	localparam logic RST_INSERT_EN_N   = 1'b1;

	// Software control bits
	typedef struct packed {
		logic sep_comp_sel;           // 1 separate, 0 composite
		logic pulse_insert_enable_n;
		logic interval_mode_enable_n; // 1 count per frame
		logic interval_sel;           // 0 short window, 1 long
		logic horiz_out_polarity;
		logic vert_out_polarity;
		logic horiz_output_enable_n;
		logic vert_output_enable_n;
		logic vert_overflow_clear;    // one-cycle write strobe
		logic horiz_overflow_clear;   // one-cycle write strobe
	} hvs_ctrl_t;

	// Status readback
	typedef struct packed {
		logic [VCNT_W-1:0] vert_period_count;
		logic [HCNT_W-1:0] horiz_pulse_count;
		logic              vert_count_overflow;
		logic              horiz_count_overflow;
		logic              horiz_in_polarity;
		logic              vert_in_polarity;
		logic              horiz_sync_level;
		logic              vert_sync_level;
	} hvs_stat_t;
endpackage

// ==== hw/hvs_filter.sv ====
// Pin synchroniser and glitch filter for one sync input.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/100ps
module hvs_filter
	import hvs_pkg::*;
#(
	parameter int MIN_CYC = GLITCH_CYC
)(
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level,
	output logic      rise
);
	logic [2:0] sync_r;
	logic [7:0] run_r;
	logic       level_r;
	logic       primed_r;

	// Three-stage synchroniser; first stage feeds only the second
	always_ff @(posedge clock)
	begin
		if (rst)
			sync_r <= 3'h0;
		else
			sync_r <= {sync_r[1:0], pin};
	end

	// Level changes only after a stable run of MIN_CYC cycles.
	// The first run after reset only adopts the idle level, so a pin
	// idling high gives no false edge.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			run_r    <= 8'h00;
			level_r  <= 1'b0;
			primed_r <= 1'b0;
		end
		else if (sync_r[2] != sync_r[1]
			|| (primed_r && sync_r[2] == level_r))
			run_r <= 8'h00;
		else if (run_r == 8'(MIN_CYC - 1))
		begin
			level_r  <= sync_r[2];
			primed_r <= 1'b1;
			run_r    <= 8'h00;
		end
		else
			run_r <= run_r + 8'h01;
	end

	assign level = level_r;
	assign rise  = primed_r && (run_r == 8'(MIN_CYC - 1)) && sync_r[2]
		&& !level_r && sync_r[2] == sync_r[1];
endmodule

// ==== verif/hvs_video_src.sv ====
// Video source model driving the separate sync pins.
// Assumes the caller runs it from falling edges of the processor clock.
`timescale 1ns/100ps
module hvs_video_src
(
	input  wire logic clock,
	output logic      horiz_sync_in,
	output logic      vert_sync_in
);
	// Horizontal idle level; high gives negative polarity sync
	logic hidle = 1'b1;

	// Lines idle, no vertical pulse at power up
	initial
	begin
		horiz_sync_in = 1'b1;
		vert_sync_in  = 1'b0;
	end

	// Hold the vertical pin at v for n cycles
	task automatic vert(input logic v, input int n);
		vert_sync_in = v;
		repeat (n) @(negedge clock);
	endtask

	// Hold the horizontal pin at h for n cycles
	task automatic horiz(input logic h, input int n);
		horiz_sync_in = h;
		repeat (n) @(negedge clock);
	endtask

	// One line: active pulse of w cycles within len cycles
	task automatic line(input int len, input int w);
		horiz_sync_in = ~hidle;
		repeat (w) @(negedge clock);
		horiz_sync_in = hidle;
		repeat (len - w) @(negedge clock);
	endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the sync processor with shortened counts.
// Assumes the video source model drives both sync pins.
`timescale 1ns/100ps
module testbench;
	import hvs_pkg::*;
	localparam int VT = 2;
	localparam int W1 = 4000;
	logic      clock        = 1'b0;
	logic      rst          = 1'b1;
	logic      g6           = 1'b0;
	logic      g7           = 1'b0;
	logic      hs;
	logic      vs;
	logic      p6;
	logic      p7;
	logic      hso;
	logic      vso;
	hvs_ctrl_t ctrl;
	hvs_stat_t stat;
	int        mismatches   = 0;
	int        total_checks = 0;
	int        n;
	int        e;
	int        frm[$];
	int        ins_seen     = 0;
	logic      hso_d        = 1'b0;

	// 200 MHz clock
	always #2.5 clock = ~clock;

	// Output line pulses that start while composite vertical is shown
	always @(negedge clock)
	begin
		if (!ctrl.sep_comp_sel && vso && hso && !hso_d)
			ins_seen++;
		hso_d <= hso;
	end

	hvs_video_src src (
		.clock         (clock),
		.horiz_sync_in (hs),
		.vert_sync_in  (vs)
	);

	hvs_sync_proc #(.VTICK(VT), .WIN0(2000), .WIN1(W1), .INSW(4),
		.WIDEN(10)) DUT (
		.clock           (clock),
		.rst             (rst),
		.horiz_sync_in   (hs),
		.vert_sync_in    (vs),
		.ctrl            (ctrl),
		.port0_pin6_gpio (g6),
		.port0_pin7_gpio (g7),
		.stat            (stat),
		.port0_pin6_out  (p6),
		.port0_pin7_out  (p7),
		.horiz_sync_out  (hso),
		.vert_sync_out   (vso)
	);

	task automatic test_done();
		if (mismatches == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Single bit against its expected level
	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: bit mismatch", $time);
		end
	endtask

	// Count within a range; prescaler phase allows one tick of slack
	task automatic chk_cnt(input logic [15:0] got, input int lo,
		input int hi);
		total_checks++;
		if ((^got) === 1'bx || got < lo || got > hi)
		begin
			mismatches++;
			$display("Error at %0t: count %0d not in %0d..%0d", $time,
				got, lo, hi);
		end
	endtask

	// One-cycle clear strobe, vertical if v else horizontal
	task automatic strobe(input logic v);
		ctrl.vert_overflow_clear  = v;
		ctrl.horiz_overflow_clear = ~v;
		@(negedge clock);
		ctrl.vert_overflow_clear  = 1'b0;
		ctrl.horiz_overflow_clear = 1'b0;
	endtask

	// Hang guard, well past the expected run of about 75k cycles
	initial
	begin
		#450000;
		mismatches++;
		test_done();
	end

	initial
	begin
		ctrl = 10'h3fc;
		void'($urandom(32'h1213d94c));
		repeat (10) @(negedge clock);
		rst = 1'b0;
		chk_cnt(16'(stat.vert_period_count), 0, 0);
		chk_cnt(16'(stat.horiz_pulse_count), 0, 0);
		// A 100 ns pulse must leave no trace
		src.vert(1'b1, 20);
		chk_bit(stat.vert_sync_level, 1'b0);
		src.vert(1'b0, 40);
		chk_bit(stat.vert_sync_level, 1'b0);
		chk_cnt(16'(stat.vert_period_count), 0, 0);
		src.vert(1'b1, 40);
		// Frames of random line count, counted against the queue
		for (int f = 0; f < 4; f++)
		begin
			src.vert(1'b0, 0);
			n = 3 + $urandom_range(0, 17);
			frm.push_back(n);
			for (int i = 0; i < n; i++)
			begin
				// Clear mid-frame, while the running count is not zero
				if (f == 2 && i == 2)
					strobe(1'b0);
				src.line(100, 30);
			end
			src.vert(1'b1, 35);
			chk_bit(stat.vert_sync_level, 1'b1);
			src.vert(1'b1, 5);
			e = frm.pop_front();
			chk_cnt(16'(stat.horiz_pulse_count), e, e);
			chk_bit(stat.horiz_count_overflow, 1'b0);
			e = (e * 100 + 40) / VT;
			chk_cnt(16'(stat.vert_period_count), e - 1, e + 1);
		end
		src.vert(1'b0, 40);
		// Shared pin muxing and output polarity, vertical pin low
		for (int k = 0; k < 16; k++)
		begin
			{ctrl.vert_output_enable_n, ctrl.horiz_output_enable_n,
				ctrl.vert_out_polarity, ctrl.horiz_out_polarity} = 4'(k);
			{g6, g7} = 2'($urandom);
			@(negedge clock);
			chk_bit(p6, ctrl.vert_output_enable_n ? g6 : vso);
			chk_bit(p7, ctrl.horiz_output_enable_n ? g7 : hso);
			chk_bit(vso, ~ctrl.vert_out_polarity);
			chk_bit(hso, ctrl.horiz_out_polarity);
		end
		// Separate sync passes even a short pulse straight through
		ctrl.vert_out_polarity = 1'b1;
		src.vert(1'b1, 1);
		chk_bit(vso, 1'b1);
		src.vert(1'b0, 40);
		// Long fixed window; the pair is never written as 00
		ctrl.interval_mode_enable_n = 1'b0;
		repeat (3 * W1 / 100) src.line(100, 30);
		e = W1 / 100;
		chk_cnt(16'(stat.horiz_pulse_count), e - 1, e + 1);
		ctrl.interval_mode_enable_n = 1'b1;
		// No vertical sync: period counter must overflow
		// Long enough to pass the first polarity sample
		repeat (560) src.line(100, 30);
		chk_bit(stat.horiz_in_polarity, 1'b0);
		chk_bit(stat.vert_in_polarity, 1'b1);
		chk_bit(stat.vert_count_overflow, 1'b1);
		strobe(1'b1);
		@(negedge clock);
		chk_bit(stat.vert_count_overflow, 1'b0);
		// Composite input: a 300-cycle pulse on the horizontal pin
		ctrl.sep_comp_sel          = 1'b0;
		ctrl.pulse_insert_enable_n = 1'b0;
		repeat (2) src.line(100, 30);
		src.horiz(1'b0, 150);
		chk_bit(vso, 1'b1);
		src.horiz(1'b0, 150);
		src.horiz(1'b1, 30);
		chk_bit(vso, 1'b1);
		src.horiz(1'b1, 100);
		chk_bit(vso, 1'b0);
		chk_cnt(16'(ins_seen), 2, 4);
		test_done();
	end
endmodule
